// >>> pmic_defs.svh
// constants shared by the supervisor end and the controller end
// assumes a 100 MHz system clock on both ends
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

// ----------------------------------------------------------------
// serial register map (7-bit addresses)
// ----------------------------------------------------------------
`define ADDR_ENABLE     7'h01
`define ADDR_UVLO_THR   7'h09
`define ADDR_INT_FLAGS  7'h0C
`define ADDR_INT_MASK   7'h0D
`define ADDR_PARK_TIME  7'h0E
`define ADDR_KEY        7'h10
`define ADDR_PROT_LO    7'h11
`define ADDR_PROT_HI    7'h27
`define ADDR_LAST       7'h7F

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define EN_MIRROR_BIT   0
`define EN_LED_BIT      1
`define FLAG_HOT        0
`define FLAG_TSD        1
`define FLAG_BATLOW     2
`define FLAG_UVLO       3
`define FLAG_MIRFLT     4
`define FLAG_SIXV       5
`define FLAG_LEDOVP     6
`define FLAG_LSLOW      7
`define KEY_FIRST       8'hBA
`define KEY_SECOND      8'hBE
`define KEY_LOCKED      8'h00
`define KEY_UNLOCKED    8'h01
`define RST_ENABLE      8'h00
`define RST_MASK        8'hDF
`define RST_UVLO_THR    5'h00
`define RST_PARK_US     7'h64
`define RST_PROT        8'h00

// ----------------------------------------------------------------
// timing (clock 100 MHz)
// ----------------------------------------------------------------
`define CLK_MHZ         100
`define PARK_MAX_US     100
`define IRQ_REARM_NS    16000
`define IRQ_REARM_CYC   ((`IRQ_REARM_NS * `CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// controller bus map (byte addresses), link clock half-period in cycles
// ----------------------------------------------------------------
`define HOST_CMD        8'h00
`define HOST_POWER      8'h04
`define HOST_STATUS     8'h08
`define HOST_DIV_HALF   8

`endif

// >>> pmic_pkg.sv
// types shared by both ends of the supervisor link
// assumes nothing beyond a SystemVerilog compiler
package pmic_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_ACTIVE, ST_PARK} pwr_state_t;
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} host_state_t;
endpackage

// >>> pmic_link_if.sv
// serial link, interrupt line and power-on pin between the two ends
// assumes open-drain lines with pull-ups, resolved here
`timescale 1ns/10ps
interface pmic_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic irq_oe;
  logic power_on_pin;
  logic miso;
  logic irq_n_line;

  // pull-up resolution of the shared wires
  assign miso       = miso_oe ? miso_out : 1'b1;
  assign irq_n_line = irq_oe ? 1'b0 : 1'b1;

  modport device (
    input  sclk, chip_select_n, mosi, power_on_pin,
    output miso_out, miso_oe, irq_oe
  );
  modport host (
    input  miso, irq_n_line,
    output sclk, chip_select_n, mosi, power_on_pin
  );
endinterface

// >>> pmic_host.sv
// controller end: apb slave that runs one command plus one data byte
// assumes the supervisor end on the link, both on i_clk
`timescale 1ns/10ps
`include "pmic_defs.svh"
module pmic_host
  import pmic_pkg::*;
#(
  parameter int DIV_HALF = `HOST_DIV_HALF
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  pmic_link_if.host        link
);
  host_state_t state_reg;
  logic [15:0] sh_reg;
  logic [7:0]  rx_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  div_reg;
  logic        power_reg;
  logic [1:0]  miso_sy;
  logic [1:0]  irq_sy;
  logic        access;
  logic        hit;
  logic        tick;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign access    = i_psel & i_penable;
  assign hit       = (i_paddr == `HOST_CMD) | (i_paddr == `HOST_POWER)
                   | (i_paddr == `HOST_STATUS);
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~hit;
  assign tick      = (div_reg == 8'(DIV_HALF - 1));

  // read data: status word, else power level, else zero
  always_comb
  begin
    o_prdata = 32'h0000_0000;
    if (i_paddr == `HOST_STATUS)
      o_prdata = {16'h0000, rx_reg, 6'h00, ~irq_sy[1], state_reg != H_IDLE};
    else if (i_paddr == `HOST_POWER)
      o_prdata = {31'h0000_0000, power_reg};
  end

  // two-flop synchronisers for the returning pins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      miso_sy <= 2'b11;
      irq_sy  <= 2'b11;
    end
    else if (i_ce)
    begin
      miso_sy <= {miso_sy[0], link.miso};
      irq_sy  <= {irq_sy[0], link.irq_n_line};
    end
  end

  // power-on pin level, toggled low then high by software
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      power_reg <= 1'b0;
    else if (i_ce && access && i_pwrite && i_paddr == `HOST_POWER)
      power_reg <= i_pwdata[0];
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  // command byte first
  // drive on fall, sample on rise
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= H_IDLE;
      sh_reg    <= 16'h0000;
      rx_reg    <= 8'h00;
      bit_reg   <= 4'h0;
      div_reg   <= 8'h00;
    end
    else if (i_ce)
    begin
      div_reg <= (state_reg == H_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
      unique case (state_reg)
        H_IDLE:
          if (access && i_pwrite && i_paddr == `HOST_CMD)
          begin
            sh_reg    <= i_pwdata[15:0];
            bit_reg   <= 4'h0;
            state_reg <= H_LOW;
          end
        // sample at the rise, before the slave reloads its next byte
        H_LOW:
          if (tick)
          begin
            rx_reg    <= {rx_reg[6:0], miso_sy[1]};
            state_reg <= H_HIGH;
          end
        H_HIGH:
          if (tick)
          begin
            sh_reg  <= {sh_reg[14:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
            state_reg <= (bit_reg == 4'hF) ? H_GAP : H_LOW;
          end
        H_GAP:
          if (tick)
            state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.chip_select_n = (state_reg == H_IDLE) | (state_reg == H_GAP);
  assign link.sclk          = (state_reg == H_HIGH);
  assign link.mosi          = sh_reg[15];
  assign link.power_on_pin  = power_reg;
endmodule

// >>> pmic_supervisor.sv
// supervisor end: fault flags, interrupt line, serial register slave
// assumes comparator levels and link pins are asynchronous to i_clk
`timescale 1ns/10ps
`include "pmic_defs.svh"
module pmic_supervisor
  import pmic_pkg::*;
#(
  parameter int CYC_PER_US = `CLK_MHZ
)(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_die_hot,
  input  wire logic       i_die_shutdown,
  input  wire logic       i_battery_low,
  input  wire logic       i_below_uvlo,
  input  wire logic       i_above_recovery,
  input  wire logic       i_mirror_reg_fault,
  input  wire logic       i_six_volt_fail,
  input  wire logic       i_led_overvoltage,
  input  wire logic       i_load_switch_low,
  output logic            o_mirror_rails_en,
  output logic            o_fast_discharge,
  output logic            o_led_en,
  output logic            o_standby,
  output logic      [4:0] o_uvlo_code,
  pmic_link_if.device     link
);
  logic [8:0]  cond_sy0;
  logic [8:0]  cond_s;
  logic [3:0]  pin_sy0;
  logic [3:0]  pin_s;
  logic        sclk_q;
  logic        off;
  logic        cs_act;
  logic        rise;
  logic        fall;
  logic [2:0]  bit_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  snap_reg;
  logic        cmd_reg;
  logic        wr_mode_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  rx_next;
  logic        byte_done;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  enable_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  flags_reg;
  logic [4:0]  uvlo_thr_reg;
  logic [6:0]  park_us_reg;
  logic        unlocked_reg;
  logic        key_stage_reg;
  logic [7:0]  prot_reg [0:22];
  logic [10:0] rearm_reg;
  logic        irq_reg;
  pwr_state_t  state_reg;
  logic [13:0] park_reg;
  logic        uvlo_lock_reg;
  logic        ls_lock_reg;
  logic        flt_lock_reg;
  logic        discharge_reg;
  logic        hw_clear;
  logic        en_refused;
  logic [6:0]  park_lim;

  // register read mux, used for first and following bytes
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    logic [6:0] idx;
    idx = a - `ADDR_PROT_LO;
    read_reg = 8'h00;
    if (a == `ADDR_ENABLE)    read_reg = enable_reg;
    if (a == `ADDR_UVLO_THR)  read_reg = {3'b000, uvlo_thr_reg};
    if (a == `ADDR_INT_FLAGS) read_reg = flags_reg;
    if (a == `ADDR_INT_MASK)  read_reg = mask_reg;
    if (a == `ADDR_PARK_TIME) read_reg = {1'b0, park_us_reg};
    if (a == `ADDR_KEY)       read_reg = unlocked_reg ? `KEY_UNLOCKED : `KEY_LOCKED;
    if (a >= `ADDR_PROT_LO && a <= `ADDR_PROT_HI) read_reg = prot_reg[idx[4:0]];
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cond_sy0 <= 9'h000;
      cond_s   <= 9'h000;
      pin_sy0  <= 4'h2;
      pin_s    <= 4'h2;
      sclk_q   <= 1'b0;
    end
    else if (i_ce)
    begin
      cond_sy0 <= {i_above_recovery, i_load_switch_low, i_led_overvoltage,
                   i_six_volt_fail, i_mirror_reg_fault, i_below_uvlo,
                   i_battery_low, i_die_shutdown, i_die_hot};
      cond_s   <= cond_sy0;
      pin_sy0  <= {link.power_on_pin, link.mosi, link.chip_select_n, link.sclk};
      pin_s    <= pin_sy0;
      sclk_q   <= pin_s[0];
    end
  end

  assign off       = ~pin_s[3];
  assign cs_act    = ~pin_s[1] & ~off;
  assign rise      = cs_act & pin_s[0] & ~sclk_q;
  assign fall      = cs_act & ~pin_s[0] & sclk_q;
  assign rx_next   = {rx_reg[6:0], pin_s[2]};
  assign byte_done = rise & (bit_reg == 3'h7);
  assign wr_fire   = byte_done & cmd_reg & wr_mode_reg;
  assign rd_fire   = byte_done & cmd_reg & ~wr_mode_reg;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  // shift in on rise, out on fall
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_reg     <= 3'h0;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      snap_reg    <= 8'h00;
      cmd_reg     <= 1'b0;
      wr_mode_reg <= 1'b0;
      addr_reg    <= 7'h00;
    end
    else if (i_ce)
    begin
      if (!cs_act)
      begin
        bit_reg <= 3'h0;
        cmd_reg <= 1'b0;
      end
      else if (rise)
      begin
        rx_reg  <= rx_next;
        bit_reg <= bit_reg + 3'h1;
        if (byte_done && !cmd_reg)
        begin
          cmd_reg     <= 1'b1;
          wr_mode_reg <= rx_next[7];
          addr_reg    <= rx_next[6:0];
          tx_reg      <= read_reg(rx_next[6:0]);
          snap_reg    <= read_reg(rx_next[6:0]);
        end
        else if (byte_done)
        begin
          addr_reg <= addr_reg + 7'h01;
          tx_reg   <= read_reg(addr_reg + 7'h01);
          snap_reg <= read_reg(addr_reg + 7'h01);
        end
      end
      else if (fall && bit_reg != 3'h0)
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  assign link.miso_out = tx_reg[7];
  assign link.miso_oe  = cs_act & cmd_reg & ~wr_mode_reg;

  // ----------------------------------------------------------------
  // configuration registers and key
  // ----------------------------------------------------------------
  // hardware clear beats software
  assign hw_clear   = (state_reg == ST_ACTIVE)
                    & (cond_s[`FLAG_TSD] | cond_s[`FLAG_UVLO]
                    | cond_s[`FLAG_MIRFLT] | cond_s[`FLAG_LSLOW]);
  assign en_refused = uvlo_lock_reg | ls_lock_reg | flt_lock_reg | ~cond_s[8]
                    | cond_s[`FLAG_TSD];
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      enable_reg    <= `RST_ENABLE;
      mask_reg      <= `RST_MASK;
      uvlo_thr_reg  <= `RST_UVLO_THR;
      park_us_reg   <= `RST_PARK_US;
      unlocked_reg  <= 1'b0;
      key_stage_reg <= 1'b0;
      for (int i = 0; i < 23; i++) prot_reg[i] <= `RST_PROT;
    end
    else if (i_ce)
    begin
      if (off)
      begin
        enable_reg    <= `RST_ENABLE;
        mask_reg      <= `RST_MASK;
        uvlo_thr_reg  <= `RST_UVLO_THR;
        park_us_reg   <= `RST_PARK_US;
        unlocked_reg  <= 1'b0;
        key_stage_reg <= 1'b0;
        for (int i = 0; i < 23; i++) prot_reg[i] <= `RST_PROT;
      end
      else
      begin
        if (wr_fire && addr_reg == `ADDR_ENABLE && !en_refused)
          enable_reg <= rx_next;
        else if (wr_fire && addr_reg == `ADDR_ENABLE)
          enable_reg <= rx_next & ~(8'h01 << `EN_MIRROR_BIT);
        if (hw_clear)
          enable_reg[`EN_MIRROR_BIT] <= 1'b0;
        if (wr_fire && addr_reg == `ADDR_INT_MASK)
          mask_reg <= rx_next;
        if (wr_fire && addr_reg == `ADDR_UVLO_THR)
          uvlo_thr_reg <= rx_next[4:0];
        if (wr_fire && addr_reg == `ADDR_PARK_TIME)
          park_us_reg <= rx_next[6:0];
        if (wr_fire && unlocked_reg && addr_reg >= `ADDR_PROT_LO
            && addr_reg <= `ADDR_PROT_HI)
          prot_reg[5'(addr_reg - `ADDR_PROT_LO)] <= rx_next;
        // key sequence, any other access breaks it
        if (wr_fire && addr_reg == `ADDR_KEY)
        begin
          key_stage_reg <= (rx_next == `KEY_FIRST);
          if (rx_next == `KEY_SECOND && key_stage_reg)
            unlocked_reg <= 1'b1;
          else if (rx_next != `KEY_FIRST)
            unlocked_reg <= 1'b0;
        end
        else if (wr_fire || rd_fire)
          key_stage_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flags and interrupt line
  // ----------------------------------------------------------------
  // conditions set flags
  // read clears reported bits, set wins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flags_reg <= 8'h00;
    else if (i_ce)
    begin
      if (off)
        flags_reg <= 8'h00;
      else if (rd_fire && addr_reg == `ADDR_INT_FLAGS)
        flags_reg <= (flags_reg & ~snap_reg) | cond_s[7:0];
      else
        flags_reg <= flags_reg | cond_s[7:0];
    end
  end

  // release after read, re-drive only once the rearm count has run out
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rearm_reg <= 11'h000;
      irq_reg   <= 1'b0;
    end
    else if (i_ce)
    begin
      if (rd_fire && addr_reg == `ADDR_INT_FLAGS)
        rearm_reg <= 11'(`IRQ_REARM_CYC);
      else if (rearm_reg != 11'h000)
        rearm_reg <= rearm_reg - 11'h001;
      irq_reg <= ~off & (|(flags_reg & ~mask_reg)) & (rearm_reg == 11'h000)
               & ~(rd_fire && addr_reg == `ADDR_INT_FLAGS);
    end
  end
  assign link.irq_oe = irq_reg;

  // ----------------------------------------------------------------
  // power state and protection
  // ----------------------------------------------------------------
  // park time limited to the maximum
  assign park_lim = (park_us_reg > 7'(`PARK_MAX_US)) ? 7'(`PARK_MAX_US) : park_us_reg;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg     <= ST_OFF;
      park_reg      <= 14'h0000;
      uvlo_lock_reg <= 1'b0;
      ls_lock_reg   <= 1'b0;
      flt_lock_reg  <= 1'b0;
      discharge_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (off)
      begin
        state_reg     <= ST_OFF;
        uvlo_lock_reg <= 1'b0;
        ls_lock_reg   <= 1'b0;
        flt_lock_reg  <= 1'b0;
        discharge_reg <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          ST_OFF:
            state_reg <= ST_STANDBY;
          ST_STANDBY:
            if (enable_reg[`EN_MIRROR_BIT])
            begin
              state_reg     <= ST_ACTIVE;
              discharge_reg <= 1'b0;
            end
          ST_ACTIVE:
            if (cond_s[`FLAG_LSLOW])
            begin
              ls_lock_reg   <= 1'b1;
              discharge_reg <= 1'b1;
              state_reg     <= ST_STANDBY;
            end
            else if (cond_s[`FLAG_UVLO])
            begin
              uvlo_lock_reg <= 1'b1;
              park_reg      <= 14'(park_lim * CYC_PER_US);
              state_reg     <= ST_PARK;
            end
            else if (cond_s[`FLAG_MIRFLT])
            begin
              flt_lock_reg <= ~mask_reg[`FLAG_MIRFLT];
              state_reg    <= ST_STANDBY;
            end
            else if (cond_s[`FLAG_TSD] || !enable_reg[`EN_MIRROR_BIT])
              state_reg <= ST_STANDBY;
          ST_PARK:
            if (cond_s[`FLAG_LSLOW] || park_reg == 14'h0000)
            begin
              discharge_reg <= 1'b1;
              ls_lock_reg   <= ls_lock_reg | cond_s[`FLAG_LSLOW];
              state_reg     <= ST_STANDBY;
            end
            else
              park_reg <= park_reg - 14'h0001;
        endcase
      end
    end
  end

  // rails held through parking, dropped after
  assign o_mirror_rails_en = (state_reg == ST_ACTIVE) | (state_reg == ST_PARK);
  assign o_fast_discharge  = discharge_reg;
  // led only while active: off in parking, with mirror rails, or on six-volt fail
  assign o_led_en          = (state_reg == ST_ACTIVE) & enable_reg[`EN_LED_BIT]
                           & ~cond_s[`FLAG_SIXV];
  assign o_standby         = (state_reg == ST_STANDBY);
  assign o_uvlo_code       = uvlo_thr_reg;
endmodule

// >>> pmic_fault_irq_spi_control_properties.sv
// checker on the link between the controller end and the supervisor end
// assumes link signals tapped as plain inputs, one clock domain
`timescale 1ns/10ps
module pmic_fault_irq_spi_control_properties (
  input logic i_clk,
  input logic i_rst_n,
  input logic sclk,
  input logic chip_select_n,
  input logic mosi,
  input logic miso_out,
  input logic miso_oe,
  input logic irq_oe,
  input logic power_on_pin
);
  localparam int REARM = 1590;
  logic        sclk_reg;
  logic [4:0]  rise_cnt;
  logic [7:0]  cmd_reg;
  logic [11:0] gap_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------
  // frame and line tracking
  // ------------------------------------------
  // clock rises since select, command byte
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_reg <= 1'b0;
      rise_cnt <= 5'h00;
      cmd_reg  <= 8'h00;
    end
    else
    begin
      sclk_reg <= sclk;
      if (chip_select_n)
        rise_cnt <= 5'h00;
      else if (sclk && !sclk_reg && rise_cnt != 5'h1F)
        rise_cnt <= rise_cnt + 5'h01;
      if (sclk && !sclk_reg && !chip_select_n && rise_cnt < 5'h08)
        cmd_reg <= {cmd_reg[6:0], mosi};
    end
  end
  // cycles since the interrupt line was freed
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      gap_cnt <= 12'hFFF;
    else if (irq_oe)
      gap_cnt <= 12'h000;
    else if (gap_cnt != 12'hFFF)
      gap_cnt <= gap_cnt + 12'h001;
  AST_CS_FLOAT: assert property (chip_select_n [*5] |-> !miso_oe)
    else $error("data out driven while deselected");
  AST_OE_NEEDS_CS: assert property ($rose(miso_oe) |-> !chip_select_n)
    else $error("data out enabled without select");
  AST_SHIFT_ON_FALL: assert property ((sclk && !chip_select_n) [*7] |-> $stable(miso_out))
    else $error("data out moved while clock high");
  AST_DATA_AFTER_CMD: assert property ($rose(miso_oe) |-> rise_cnt == 5'h08)
    else $error("data out not after command byte");
  AST_WRITE_NO_DRIVE: assert property (miso_oe |-> !cmd_reg[7])
    else $error("data out driven in write frame");
  AST_OFF_SILENT: assert property ((!power_on_pin) [*6] |-> !miso_oe && !irq_oe)
    else $error("outputs active in off mode");
  AST_READ_RELEASES: assert property ($changed(rise_cnt) && rise_cnt == 5'h10
    && cmd_reg == 8'h0C && irq_oe |-> ##[1:10] !irq_oe)
    else $error("flags read kept line low");
  AST_REARM_GAP: assert property ($rose(irq_oe) |-> gap_cnt >= REARM)
    else $error("line pulled again too soon");
  cover property (rise_cnt == 5'h10 && cmd_reg == 8'h0C);
  cover property ($rose(irq_oe));
  cover property ($rose(miso_oe));
endmodule

// >>> pmic_fault_irq_spi_control_tb.sv
// bench: apb controller end drives the supervisor end over the link
// assumes one 100 MHz clock, comparator levels driven from here
`timescale 1ns/10ps
`include "pmic_defs.svh"
module pmic_fault_irq_spi_control_tb;
  localparam logic [7:0] HOLD_MIR = 8'h65;
  localparam logic [7:0] HOLD_LED = 8'h45;
  localparam logic [7:0] AFT_MIR  = 8'h67;
  logic        i_clk, i_rst_n, psel, pen, pwr, serr, above, pready, pslverr;
  logic        mir, fdis, led, stby;
  logic [4:0]  code;
  logic [7:0]  paddr, flt, q;
  logic [31:0] pwdata, prdata, rnd, r;
  logic [15:0] ops [21] = '{16'h95FF, 16'h1500, 16'h90BA, 16'h1000, 16'h90BE, 16'h1000,
    16'h90BA, 16'h90BE, 16'h1000, 16'h91FF, 16'h1100, 16'hA7FF, 16'h2700, 16'hA8FF,
    16'h2800, 16'h90BA, 16'h1000, 16'h9055, 16'h1000, 16'hA7FF, 16'h2700};
  int          mismatches, check_count, n, mdl [128];
  bit          unl, arm;
  pmic_link_if link ();
  pmic_host u_pmic_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link));
  pmic_supervisor #(.CYC_PER_US(1)) u_pmic_supervisor (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(1'b1), .i_die_hot(flt[0]), .i_die_shutdown(flt[1]), .i_battery_low(flt[2]),
    .i_below_uvlo(flt[3]), .i_above_recovery(above), .i_mirror_reg_fault(flt[4]),
    .i_six_volt_fail(flt[5]), .i_led_overvoltage(flt[6]), .i_load_switch_low(flt[7]),
    .o_mirror_rails_en(mir), .o_fast_discharge(fdis), .o_led_en(led), .o_standby(stby),
    .o_uvlo_code(code), .link(link));
  pmic_fault_irq_spi_control_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .sclk(link.sclk), .chip_select_n(link.chip_select_n), .mosi(link.mosi),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe), .irq_oe(link.irq_oe),
    .power_on_pin(link.power_on_pin));
  // ------------------------------------------
  // clock, tasks, sequence
  // ------------------------------------------
  // free-running system clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50)
    begin
      mismatches++;
      end_sim();
    end
  endtask
  // one command plus data byte, then poll busy
  task automatic spi(input logic [15:0] c);
    int k;
    apb(1'b1, `HOST_CMD, {16'h0000, c});
    k = 0;
    do
    begin
      apb(1'b0, `HOST_STATUS, 32'h0);
      k++;
    end
    while (r[0] !== 1'b0 && k < 400);
    if (k >= 400)
    begin
      mismatches++;
      end_sim();
    end
    q = r[15:8];
  endtask
  task automatic pin(input logic v);
    apb(1'b1, `HOST_POWER, {31'h0, v});
    repeat (10) @(posedge i_clk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // key and protected-range model
  task automatic mdl_acc(input logic [15:0] c);
    int a;
    a = c[14:8];
    if (!c[15])
      chk("reg_rd", q, a == 16 ? unl : mdl[a]);
    if (c[15] && a == 16)
      unl = (c[7:0] == 8'hBA) ? unl : (arm && c[7:0] == 8'hBE);
    if (c[15] && a > 16 && a < 40 && unl)
      mdl[a] = c[7:0];
    arm = c[15] && a == 16 && c[7:0] == 8'hBA;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_clk);
    mismatches++;
    end_sim();
  end
  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    {psel, pen, pwr, paddr, pwdata, flt, above} = '0;
    rnd = 32'h5653F89B;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    above <= 1'b1;
    spi(16'h0D00);
    chk("off_rd", q, 8'hFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk("apb_err", {r[30:0], serr}, 32'h1);
    pin(1'b1);
    apb(1'b0, `HOST_POWER, 32'h0);
    chk("pin_rd", r, 32'h1);
    spi(16'h0D00);
    chk("mask_rst", q, 8'hDF);
    spi(16'h891E);
    chk("uvlo_code", code, 5'h1E);
    foreach (ops[i])
    begin
      if (ops[i][7:0] == 8'hFF)
        ops[i][7:0] = rnd[7:0];
      rnd = lfsr(rnd);
      spi(ops[i]);
      mdl_acc(ops[i]);
    end
    for (int b = 0; b < 8; b++)
    begin
      pin(1'b0);
      pin(1'b1);
      spi(16'h8D00);
      spi(16'h8E05);
      spi(16'h8103);
      chk("on", {mir, led}, 2'b11);
      flt[b] <= 1'b1;
      above <= (b != 3);
      repeat (300) @(posedge i_clk);
      chk("irq_low", link.irq_n_line, 0);
      apb(1'b0, `HOST_STATUS, 32'h0);
      chk("irq_stat", r[1], 1);
      chk("hold_mir", mir, HOLD_MIR[b]);
      if (b != 7) chk("hold_led", led, HOLD_LED[b]);
      if (b == 3 || b == 7) chk("discharge", fdis, 1);
      if (b == 3) chk("standby", stby, 1);
      flt[b] <= 1'b0;
      above <= 1'b1;
      spi(16'h0C00);
      chk("flags", q, 8'h01 << b);
      chk("irq_free", link.irq_n_line, 1);
      spi(16'h0C00);
      chk("cleared", q, 0);
      spi(16'h0100);
      if (b == 3 || b == 4) chk("en_bit", q[0], 0);
      spi(16'h8103);
      repeat (20) @(posedge i_clk);
      chk("after_mir", mir, AFT_MIR[b]);
      repeat (1600) @(posedge i_clk);
    end
    pin(1'b0);
    pin(1'b1);
    spi(16'h8D00);
    flt[6] <= 1'b1;
    repeat (50) @(posedge i_clk);
    spi(16'h0C00);
    chk("persist", q, 8'h40);
    for (n = 0; link.irq_n_line !== 1'b0 && n < 3300; n++) @(posedge i_clk);
    chk("rearm", n < 3200, 1);
    flt[6] <= 1'b0;
    spi(16'h0C00);
    spi(16'h8DFF);
    spi(16'h8103);
    flt[4] <= 1'b1;
    repeat (50) @(posedge i_clk);
    chk("masked_irq", {link.irq_n_line, mir}, 2'b10);
    flt[4] <= 1'b0;
    spi(16'h0C00);
    chk("masked_flag", q, 8'h10);
    spi(16'h8103);
    repeat (20) @(posedge i_clk);
    chk("restart", mir, 1);
    end_sim();
  end
endmodule
